// >>> pkg/ptc_pkg.sv
// constants for the periodic timer control and data register slice
package ptc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL_ZERO = 4'h0;
  localparam logic [3:0] IDX_CTRL_ONE = 4'h1;
  localparam logic [3:0] IDX_CTRL_TWO = 4'h2;
  localparam logic [3:0] IDX_COUNT_LO = 4'h3;
  localparam logic [3:0] IDX_COUNT_HI = 4'h4;
  localparam logic [3:0] IDX_CMPA_LO = 4'h5;
  localparam logic [3:0] IDX_CMPA_HI = 4'h6;
  localparam logic [3:0] IDX_CMPB_LO = 4'h7;
  localparam logic [3:0] IDX_CMPB_HI = 4'h8;
  localparam logic [3:0] IDX_PERIOD_LO = 4'h9;
  localparam logic [3:0] IDX_PERIOD_HI = 4'hA;
  localparam logic [3:0] IDX_LAST = 4'hA;
  localparam int ADDR_W = 6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // timer_control_zero
  localparam int F_PAUSE = 7;
  localparam int F_ON = 3;
  // timer_control_one
  localparam int F_MODE_HI = 7;
  localparam int F_MODE_LO = 6;
  localparam int F_ACT_HI = 5;
  localparam int F_ACT_LO = 4;
  localparam int F_INIT = 3;
  localparam int F_INV = 2;
  localparam int F_CAPSRC = 1;
  localparam int F_CLRSEL = 0;
  // timer_control_two
  localparam int F_CCLR_HI = 2;
  localparam int F_CCLR_LO = 1;
  localparam int F_EDGE = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_HI = 2'h0;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTC_MODE_CMP,
    PTC_MODE_CAP,
    PTC_MODE_PWM,
    PTC_MODE_TMR
  } ptc_mode_e;

  localparam logic [1:0] ACT_NONE = 2'b00;
  localparam logic [1:0] ACT_LOW = 2'b01;
  localparam logic [1:0] ACT_HIGH = 2'b10;
  localparam logic [1:0] ACT_TOGGLE = 2'b11;
  // pwm-mode meaning of the action field
  localparam logic [1:0] PWM_INACTIVE = 2'b00;
  localparam logic [1:0] PWM_ACTIVE = 2'b01;
  localparam logic [1:0] PWM_RUN = 2'b10;
  localparam logic [1:0] PWM_PULSE = 2'b11;
  // capture-mode edge and clear selections
  localparam logic [1:0] CAP_RISE = 2'b00;
  localparam logic [1:0] CAP_FALL = 2'b01;
  localparam logic [1:0] CAP_BOTH = 2'b10;
  localparam logic [1:0] CCLR_P_ONLY = 2'b00;
  localparam logic [1:0] CCLR_RISE = 2'b01;
  localparam logic [1:0] CCLR_FALL = 2'b10;
  localparam logic [1:0] CCLR_BOTH = 2'b11;

endpackage : ptc_pkg

// >>> src/ptc_timer.sv
// periodic timer: control, compare, capture and count registers on avalon-mm
`timescale 1ns/1ns
`default_nettype none

module ptc_timer
  import ptc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ptc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic capture_input_pin,
  input wire logic external_clock_pin,
  output logic timer_output_pin,
  output logic [CNT_W-1:0] count_value
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the high registers carry at most 8 bits above the low byte
  if (CNT_W <= 8 || CNT_W > 16) begin : g_bad_width
    $error("ptc_timer: CNT_W must lie in 9..16");
  end

  localparam int HI_W = CNT_W - 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic on_q, on_d, pause_q, pause_d, on_prev_q;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [1:0] cclr_q, cclr_d;
  logic edge_flag_q, edge_flag_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, cmpa_q, cmpa_d, cmpb_q, cmpb_d, per_q, per_d;
  logic out_q, out_d;
  logic cap_prev_q, ext_prev_q;
  logic ack_q;
  logic [31:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] reg_index(input logic [ptc_pkg::ADDR_W-1:0] a);
    reg_index = a[ptc_pkg::ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
    hi_byte = 8'h00;
    hi_byte[HI_W-1:0] = v[CNT_W-1:8];
  endfunction : hi_byte

  wire logic req = avs_read | avs_write;
  wire logic [3:0] idx = reg_index(avs_address);
  wire logic aligned = (avs_address[1:0] == 2'b00);
  wire logic wr_go = avs_write & ack_q & aligned & avs_byteenable[0];
  wire logic [7:0] wb = avs_writedata[7:0];
  wire logic wr_c0 = wr_go && (idx == IDX_CTRL_ZERO);
  wire logic wr_c1 = wr_go && (idx == IDX_CTRL_ONE);
  wire logic wr_c2 = wr_go && (idx == IDX_CTRL_TWO);
  wire logic wr_al = wr_go && (idx == IDX_CMPA_LO);
  wire logic wr_ah = wr_go && (idx == IDX_CMPA_HI);
  wire logic wr_bl = wr_go && (idx == IDX_CMPB_LO);
  wire logic wr_bh = wr_go && (idx == IDX_CMPB_HI);
  wire logic wr_pl = wr_go && (idx == IDX_PERIOD_LO);
  wire logic wr_ph = wr_go && (idx == IDX_PERIOD_HI);

  wire ptc_mode_e mode = ptc_mode_e'(ctrl1_q[F_MODE_HI:F_MODE_LO]);
  wire logic [1:0] act = ctrl1_q[F_ACT_HI:F_ACT_LO];
  wire logic init_lvl = ctrl1_q[F_INIT];
  wire logic invert = ctrl1_q[F_INV];
  wire logic m_cmp = (mode == PTC_MODE_CMP);
  wire logic m_cap = (mode == PTC_MODE_CAP);
  wire logic m_pwm = (mode == PTC_MODE_PWM);
  wire logic m_tmr = (mode == PTC_MODE_TMR);
  wire logic m_pulse = m_pwm && (act == PWM_PULSE);

  // ----------------------------------------------------------------
  // counter control and comparators
  // ----------------------------------------------------------------
  wire logic on_rise = on_q & ~on_prev_q;
  wire logic running = on_q & ~pause_q;
  wire logic match_a = running && (cnt_q == cmpa_q);
  wire logic per_zero = (per_q == CNT_ZERO);
  wire logic match_p = running && !per_zero && (cnt_q == per_q);

  wire logic cap_src = ctrl1_q[F_CAPSRC] ? external_clock_pin : capture_input_pin;
  wire logic cap_prev = ctrl1_q[F_CAPSRC] ? ext_prev_q : cap_prev_q;
  wire logic cap_rise = running & cap_src & ~cap_prev;
  wire logic cap_fall = running & ~cap_src & cap_prev;
  wire logic ext_rise = external_clock_pin & ~ext_prev_q;

  // capture routing: split mode sends rising edges to compare B
  wire logic cap_split = (cclr_q != CCLR_P_ONLY);
  wire logic cap_take_r = (act == CAP_RISE) || (act == CAP_BOTH);
  wire logic cap_take_f = (act == CAP_FALL) || (act == CAP_BOTH);
  wire logic lat_rise = m_cap && cap_rise && cap_take_r;
  wire logic lat_fall = m_cap && cap_fall && cap_take_f;

  // capture clear only in capture mode
  wire logic edge_clr = m_cap && (
      ((cclr_q == CCLR_RISE) && cap_rise) ||
      ((cclr_q == CCLR_FALL) && cap_fall) ||
      ((cclr_q == CCLR_BOTH) && (cap_rise || cap_fall)));

  // clear select used only in compare and timer modes
  // clear on period match; overflow wraps naturally when period is zero
  wire logic clr_sel = ctrl1_q[F_CLRSEL] && (m_cmp || m_tmr);
  wire logic cnt_clr = clr_sel ? match_a : (match_p || edge_clr);

  // single pulse ends at comparator A match
  wire logic pulse_end = m_pulse && match_a;

  always_comb begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = CNT_ZERO;
    end else if (running && !m_pulse && cnt_clr) begin
      cnt_d = CNT_ZERO;
    end else if (running && !pulse_end) begin
      cnt_d = cnt_q + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // output logic
  // ----------------------------------------------------------------
  // pwm level: duty at or above period gives full duty
  wire logic [CNT_W:0] per_eff = per_zero ? {1'b1, CNT_ZERO} : {1'b0, per_q};
  wire logic pwm_on = ({1'b0, cmpa_q} >= per_eff) || (cnt_q < cmpa_q);

  always_comb begin
    out_d = out_q;
    case (mode)
      PTC_MODE_CMP: begin
        if (on_rise) begin
          out_d = init_lvl;
        end else if (match_a && !(clr_sel == 1'b0 && cmpa_q == CNT_ZERO)) begin
          // only a differing level moves the output
          case (act)
            ACT_LOW: out_d = 1'b0;
            ACT_HIGH: out_d = 1'b1;
            ACT_TOGGLE: out_d = ~out_q;
            default: out_d = out_q;
          endcase
        end
      end
      PTC_MODE_PWM: begin
        case (act)
          PWM_INACTIVE: out_d = ~init_lvl;
          PWM_ACTIVE: out_d = init_lvl;
          PWM_RUN: out_d = running && pwm_on ? init_lvl : ~init_lvl;
          default: begin
            // pulse leading edge at counter_on rise
            if (on_rise) begin
              out_d = init_lvl;
            end else if (pulse_end || !on_q) begin
              out_d = ~init_lvl;
            end
          end
        endcase
      end
      default: out_d = out_q;
    endcase
  end

  // timer mode drives a quiet pin
  wire logic pin_level = m_tmr ? 1'b0 : (out_q ^ invert);

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always_comb begin
    on_d = on_q;
    pause_d = pause_q;
    if (wr_c0) begin
      on_d = wb[F_ON];
      pause_d = wb[F_PAUSE];
    end
    // an external pin edge can start a single pulse
    if (m_pulse && ext_rise && !on_q) begin
      on_d = 1'b1;
    end
    // hardware stop beats a same-cycle software write
    if (pulse_end) begin
      on_d = 1'b0;
    end
  end

  // action bits are taken as written, also while the counter is running
  assign ctrl1_d = wr_c1 ? wb : ctrl1_q;
  assign cclr_d = wr_c2 ? wb[F_CCLR_HI:F_CCLR_LO] : cclr_q;

  // flag meaningful only with edge clear enabled
  assign edge_flag_d = lat_rise ? 1'b1 : (lat_fall ? 1'b0 : edge_flag_q);

  // compare A register pair; capture latch wins over a write
  always_comb begin
    cmpa_d = cmpa_q;
    if (wr_al) begin
      cmpa_d[7:0] = wb;
    end
    if (wr_ah) begin
      cmpa_d[CNT_W-1:8] = wb[HI_W-1:0];
    end
    if (lat_fall || (lat_rise && !cap_split)) begin
      cmpa_d = cnt_q;
    end
  end

  always_comb begin
    cmpb_d = cmpb_q;
    if (wr_bl) begin
      cmpb_d[7:0] = wb;
    end
    if (wr_bh) begin
      cmpb_d[CNT_W-1:8] = wb[HI_W-1:0];
    end
    if (lat_rise && cap_split) begin
      cmpb_d = cnt_q;
    end
  end

  // period low byte, high bits alongside
  always_comb begin
    per_d = per_q;
    if (wr_pl) begin
      per_d[7:0] = wb;
    end
    if (wr_ph) begin
      per_d[CNT_W-1:8] = wb[HI_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // all eleven registers in the low byte, upper bits zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!aligned) begin
      rdata_d = 32'h0000_0000;
    end else if (idx == IDX_CTRL_ZERO) begin
      rdata_d[F_ON] = on_q;
      rdata_d[F_PAUSE] = pause_q;
    end else if (idx == IDX_CTRL_ONE) begin
      rdata_d[7:0] = ctrl1_q;
    end else if (idx == IDX_CTRL_TWO) begin
      rdata_d[F_CCLR_HI:F_CCLR_LO] = cclr_q;
      rdata_d[F_EDGE] = edge_flag_q;
    end else if (idx == IDX_COUNT_LO) begin
      rdata_d[7:0] = cnt_q[7:0];
    end else if (idx == IDX_COUNT_HI) begin
      rdata_d[7:0] = hi_byte(cnt_q);
    end else if (idx == IDX_CMPA_LO) begin
      rdata_d[7:0] = cmpa_q[7:0];
    end else if (idx == IDX_CMPA_HI) begin
      rdata_d[7:0] = hi_byte(cmpa_q);
    end else if (idx == IDX_CMPB_LO) begin
      rdata_d[7:0] = cmpb_q[7:0];
    end else if (idx == IDX_CMPB_HI) begin
      rdata_d[7:0] = hi_byte(cmpb_q);
    end else if (idx == IDX_PERIOD_LO) begin
      rdata_d[7:0] = per_q[7:0];
    end else if (idx == IDX_PERIOD_HI) begin
      rdata_d[7:0] = hi_byte(per_q);
    end
  end

  // one wait cycle: data is registered first, then presented
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;
  assign timer_output_pin = pin_level;
  assign count_value = cnt_q;

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_q <= 1'b0;
      pause_q <= 1'b0;
      on_prev_q <= 1'b0;
      ctrl1_q <= RST_BYTE;
      cclr_q <= RST_HI;
      edge_flag_q <= 1'b0;
    end else begin
      on_q <= on_d;
      pause_q <= pause_d;
      on_prev_q <= on_q;
      ctrl1_q <= ctrl1_d;
      cclr_q <= cclr_d;
      edge_flag_q <= edge_flag_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= CNT_ZERO;
      cmpa_q <= CNT_ZERO;
      cmpb_q <= CNT_ZERO;
      per_q <= CNT_ZERO;
      out_q <= 1'b0;
      cap_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cmpa_q <= cmpa_d;
      cmpb_q <= cmpb_d;
      per_q <= per_d;
      out_q <= out_d;
      cap_prev_q <= capture_input_pin;
      ext_prev_q <= external_clock_pin;
    end
  end

endmodule : ptc_timer

`default_nettype wire

// >>> tb/ptc_timer_props.sv
// assertion checker for the periodic timer register slice
`timescale 1ns/1ns
`default_nettype none

module ptc_timer_props
  import ptc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic capture_input_pin,
  input wire logic external_clock_pin,
  input wire logic timer_output_pin,
  input wire logic [CNT_W-1:0] count_value
);
  // ----------------------------------------------------------------
  // shadow of software writes
  // ----------------------------------------------------------------
  // misses the single-pulse self clear, so pwm mode is kept out of every check below that uses it except a_on_zero
  logic [7:0] c1_q;
  logic on_q;
  logic pau_q;
  logic [CNT_W-1:0] ca_q;
  wire [3:0] ix = avs_address[5:2];
  wire wok = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[1:0] == 2'b00;
  wire on_up = wok && ix == IDX_CTRL_ZERO && avs_writedata[F_ON] && !on_q;
  wire [1:0] md = c1_q[F_MODE_HI:F_MODE_LO];
  wire cnt_rd = avs_read && !avs_waitrequest && avs_address == {IDX_COUNT_LO, 2'b00};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c1_q <= '0;
      on_q <= 1'b0;
      pau_q <= 1'b0;
      ca_q <= '0;
    end else if (wok) begin
      if (ix == IDX_CTRL_ZERO) begin
        on_q <= avs_writedata[F_ON];
        pau_q <= avs_writedata[F_PAUSE];
      end
      if (ix == IDX_CTRL_ONE) c1_q <= avs_writedata[7:0];
      if (ix == IDX_CMPA_LO) ca_q[7:0] <= avs_writedata[7:0];
      if (ix == IDX_CMPA_HI) ca_q[CNT_W-1:8] <= avs_writedata[CNT_W-9:0];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state longer than one cycle");

  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == '0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");

  property p_cnt_lo;
    cnt_rd |-> avs_readdata[7:0] == $past(count_value[7:0]);
  endproperty
  a_cnt_lo: assert property (p_cnt_lo) else $error("count low byte read wrong");

  property p_tmr_quiet;
    md == PTC_MODE_TMR |-> !timer_output_pin;
  endproperty
  a_tmr_quiet: assert property (p_tmr_quiet) else $error("pin active in timer mode");

  property p_on_zero;
    on_up |-> ##[1:3] count_value == '0;
  endproperty
  a_on_zero: assert property (p_on_zero) else $error("count not zeroed on start");

  property p_init_lvl;
    on_up && md == PTC_MODE_CMP |-> ##[1:3] timer_output_pin == (c1_q[F_INIT] ^ c1_q[F_INV]);
  endproperty
  a_init_lvl: assert property (p_init_lvl) else $error("pin not at initial level");

  property p_clr_a;
    on_q && !pau_q && md == PTC_MODE_CMP && c1_q[F_CLRSEL] && ca_q != '0 && count_value == ca_q
      |=> count_value == '0;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("compare A match did not clear");

  property p_hold_off;
    !on_q && !$past(on_q) && (md == PTC_MODE_CMP || md == PTC_MODE_TMR) |-> $stable(count_value);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while off");

  c_on_up: cover property (on_up);
  c_clr_a: cover property (on_q && c1_q[F_CLRSEL] && count_value == ca_q);
  c_tmr: cover property (on_q && md == PTC_MODE_TMR);

endmodule : ptc_timer_props

bind ptc_timer ptc_timer_props #(
  .CNT_W(CNT_W)
) u_props (
  .clk(clk),
  .arst_n(arst_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .capture_input_pin(capture_input_pin),
  .external_clock_pin(external_clock_pin),
  .timer_output_pin(timer_output_pin),
  .count_value(count_value)
);

`default_nettype wire

// >>> tb/test_ptc_timer.sv
// self-checking bench for the periodic timer register slice
`timescale 1ns/1ns
`default_nettype none

module test_ptc_timer
  import ptc_pkg::*;
;
  logic clk, arst_n, rd_en, wr_en, cap_pin, ext_pin, wait_o, pin_o;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  logic [9:0] cnt;
  int fails, checked;

  ptc_timer uut (
    .clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_o), .capture_input_pin(cap_pin), .external_clock_pin(ext_pin),
    .timer_output_pin(pin_o), .count_value(cnt)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] e, output logic [7:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h00_0000, d};
    be <= e;
    wr_en <= w;
    rd_en <= !w;
    // read right after the edge: outputs still hold what that edge sampled
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    q = rdat[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, {i, 2'b00}, d, 4'h1, q);
  endtask : wr

  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, {i, 2'b00}, 8'h00, 4'h1, q);
    check(q, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : idle

  // stops the timer, loads control one, compare A and the period low byte, restarts it
  task automatic cfg(input logic [7:0] c1, input logic [7:0] al, input logic [7:0] ah,
                     input logic [7:0] pl);
    wr(IDX_CTRL_ZERO, 8'h00);
    // action bits are written here while the timer is stopped
    wr(IDX_CTRL_ONE, c1);
    wr(IDX_CMPA_LO, al);
    wr(IDX_CMPA_HI, ah);
    wr(IDX_PERIOD_LO, pl);
    wr(IDX_CTRL_ZERO, 8'h08);
  endtask : cfg

  task automatic peak(input int n, output logic [9:0] m);
    m = '0;
    repeat (n) begin
      @(negedge clk);
      if (cnt > m) m = cnt;
    end
  endtask : peak

  task automatic complete_run;
    $display("counts: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [9:0] m;
    logic [7:0] q;
    logic iv, nv, ex;
    int n;
    arst_n = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    adr = '0;
    wdat = '0;
    be = 4'h0;
    cap_pin = 1'b0;
    ext_pin = 1'b0;
    fails = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i <= 10; i++) rd(i[3:0], 8'h00);
    wr(IDX_CMPA_LO, 8'hA5);
    wr(IDX_CMPA_HI, 8'hFF);
    wr(IDX_CMPB_LO, 8'h5A);
    wr(IDX_CMPB_HI, 8'hFF);
    wr(IDX_PERIOD_LO, 8'hC3);
    wr(IDX_COUNT_LO, 8'hFF);
    wr(IDX_CTRL_TWO, 8'hFF);
    // unaligned and lane-less writes change nothing, an unmapped read returns zero
    bus(1'b1, 6'h15, 8'h00, 4'h1, q);
    bus(1'b1, {IDX_CMPB_LO, 2'b00}, 8'h00, 4'h0, q);
    bus(1'b0, 6'h2C, 8'h00, 4'h1, q);
    check(q, 8'h00);
    rd(IDX_CMPA_LO, 8'hA5);
    rd(IDX_CMPA_HI, 8'h03);
    rd(IDX_CMPB_LO, 8'h5A);
    rd(IDX_CMPB_HI, 8'h03);
    rd(IDX_PERIOD_LO, 8'hC3);
    rd(IDX_COUNT_LO, 8'h00);
    rd(IDX_CTRL_TWO, 8'h06);
    $display("test done: registers");
    cfg(8'h00, 8'h00, 8'h00, 8'h03);
    peak(20, m);
    check(m, 10'h003);
    wr(IDX_CTRL_ZERO, 8'h88);
    bus(1'b0, {IDX_COUNT_LO, 2'b00}, 8'h00, 4'h1, q);
    check(q <= 8'h03, 1'b1);
    rd(IDX_COUNT_HI, 8'h00);
    cfg(8'h01, 8'h05, 8'h00, 8'h00);
    peak(20, m);
    check(m, 10'h005);
    cfg(8'hA1, 8'h02, 8'h00, 8'h06);
    peak(20, m);
    check(m, 10'h006);
    // capture clear field is still 11 here, but compare mode must ignore it
    cfg(8'h00, 8'h00, 8'h00, 8'h00);
    idle(30);
    @(posedge clk);
    cap_pin <= 1'b1;
    idle(4);
    check(cnt >= 10'h01E, 1'b1);
    $display("test done: counter clear");
    for (int k = 0; k < 16; k++) begin
      iv = k[2];
      nv = k[3];
      cfg({2'b00, k[1:0], iv, nv, 2'b00}, 8'h04, 8'h00, 8'h00);
      idle(2);
      check(pin_o, iv ^ nv);
      idle(10);
      ex = (k[1:0] == 2'b00) ? iv : (k[1:0] == 2'b11) ? !iv : k[1];
      check(pin_o, ex ^ nv);
    end
    // inactive, active and full-duty run levels of the pwm output
    for (int k = 0; k < 12; k++) begin
      iv = k[0];
      nv = k[1];
      cfg({2'b10, k[3:2], iv, nv, 2'b00}, 8'hFF, 8'h03, 8'h08);
      idle(3);
      n = 0;
      repeat (12) begin
        @(negedge clk);
        if (pin_o !== (((k[3:2] != 2'b00) ? iv : !iv) ^ nv)) n++;
      end
      check(n, 0);
    end
    cfg(8'hB8, 8'h06, 8'h00, 8'h00);
    idle(2);
    check(pin_o, 1'b1);
    idle(15);
    check(pin_o, 1'b0);
    rd(IDX_CTRL_ZERO, 8'h00);
    cfg(8'hCC, 8'h04, 8'h00, 8'h00);
    idle(12);
    check(pin_o, 1'b0);
    $display("test done: output modes");
    @(posedge clk);
    cap_pin <= 1'b0;
    wr(IDX_CTRL_TWO, 8'h02);
    cfg(8'h40, 8'h00, 8'h00, 8'h00);
    idle(30);
    @(posedge clk);
    cap_pin <= 1'b1;
    idle(4);
    check(cnt < 10'h008, 1'b1);
    // flag read only while an edge clear is selected
    rd(IDX_CTRL_TWO, 8'h03);
    wr(IDX_CTRL_ONE, 8'h50);
    wr(IDX_CTRL_TWO, 8'h04);
    idle(30);
    @(posedge clk);
    cap_pin <= 1'b0;
    idle(4);
    check(cnt < 10'h008, 1'b1);
    rd(IDX_CTRL_TWO, 8'h04);
    // external pin as source: the capture pin must now be ignored
    wr(IDX_CTRL_ONE, 8'h42);
    wr(IDX_CTRL_TWO, 8'h02);
    idle(30);
    @(posedge clk);
    cap_pin <= 1'b1;
    idle(4);
    check(cnt >= 10'h01E, 1'b1);
    @(posedge clk);
    ext_pin <= 1'b1;
    idle(4);
    check(cnt < 10'h008, 1'b1);
    $display("test done: capture");
    complete_run();
  end

endmodule : test_ptc_timer

`default_nettype wire
